// ==== aidr_diag_record.sv ====
// Purpose: Read-only diagnostic record of a four-channel analog input module.
// Assumes: 100 MHz clock; the coupler reads one record byte per request.
// Notes: Answers come one cycle after the request; no interrupt is raised.
`timescale 1ns/100ps
`default_nettype none
module aidr_diag_record (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Channel conditions from the measurement front end.
    input wire aidr_pkg::aidr_chan_in_t chan_cond_in [aidr_pkg::NUM_CHAN],
    // Record read port toward the backplane coupler.
    input wire aidr_pkg::aidr_rd_req_t rd_req_in,
    output aidr_pkg::aidr_rd_rsp_t rd_rsp_out,
    // Channel indicators and summary.
    output logic [3:0] chan_led_out,
    output logic chan_error_out
);
    import aidr_pkg::*;

    typedef struct packed {
        logic [6:0] presc;
        logic [31:0] ticker;
        logic [31:0] stamp;
        logic [7:0] rd_data;
        logic rd_valid;
        logic [3:0] led;
        logic chan_err;
    } aidr_top_st_t;

    aidr_top_st_t st_q;
    aidr_top_st_t st_d;

    logic [7:0] chan_flags [NUM_CHAN];
    logic [NUM_CHAN-1:0] chan_led;
    logic [NUM_CHAN-1:0] chan_event;
    logic [7:0] summary;
    logic [7:0] general_diag;
    logic [7:0] rd_byte;
    logic any_event;
    logic tick;

    // One error byte builder per channel.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
            aidr_chan_err u_chan (
                .core_clk_in(core_clk_in),
                .reset_in(reset_in),
                .cond_in(chan_cond_in[gi]),
                .flags_out(chan_flags[gi]),
                .led_out(chan_led[gi]),
                .event_out(chan_event[gi])
            );
        end
    endgenerate

    // Summary and general diagnostic bytes derive from the channel flags.
    always_comb begin
        summary = BYTE_ZERO;
        for (int i = 0; i < NUM_CHAN; i++) begin
            summary[i] = |chan_flags[i];
        end
        general_diag = BYTE_ZERO;
        general_diag[BIT_GEN_CHAN_ERR] = |summary;
        any_event = |chan_event;
        tick = (st_q.presc == PRESCALE_LAST);
    end

    // Record byte selection; unmapped offsets read as zero.
    always_comb begin
        rd_byte = BYTE_ZERO;
        case (rd_req_in.addr)
            OFF_GENERAL_DIAG: rd_byte = general_diag;
            OFF_MODULE_INFO: rd_byte = MODULE_INFO_VAL;
            OFF_CHANNEL_KIND: rd_byte = KIND_ANALOG_IN;
            OFF_DIAG_BITS: rd_byte = DIAG_BITS_VAL;
            OFF_CHANNEL_COUNT: rd_byte = CHANNEL_COUNT_VAL;
            OFF_GROUP_SUMMARY: rd_byte = summary;
            OFF_CHAN0_FLAGS: rd_byte = chan_flags[0];
            5'h09: rd_byte = chan_flags[1];
            5'h0A: rd_byte = chan_flags[2];
            5'h0B: rd_byte = chan_flags[3];
            // Timestamp goes out most significant byte first.
            OFF_TIMESTAMP: rd_byte = st_q.stamp[31:24];
            5'h11: rd_byte = st_q.stamp[23:16];
            5'h12: rd_byte = st_q.stamp[15:8];
            5'h13: rd_byte = st_q.stamp[7:0];
            default: rd_byte = BYTE_ZERO;
        endcase
    end

    // Next state: prescaler, ticker, timestamp capture and read answer.
    always_comb begin
        st_d = st_q;
        if (tick) begin
            st_d.presc = '0;
            // Natural 32-bit overflow gives the wrap to zero.
            st_d.ticker = st_q.ticker + 32'h0000_0001;
        end else begin
            st_d.presc = st_q.presc + 7'h01;
        end
        // A later event overwrites the stamp; only the newest is kept.
        if (any_event) begin
            st_d.stamp = st_q.ticker;
        end
        st_d.rd_valid = rd_req_in.en;
        st_d.rd_data = rd_req_in.en ? rd_byte : BYTE_ZERO;
        st_d.led = chan_led;
        st_d.chan_err = |summary;
    end

    // The ticker clears at reset so it starts from zero at power-on.
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st_q <= '0;
            st_q.ticker <= TICKER_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_rsp_out.valid = st_q.rd_valid;
    assign rd_rsp_out.data = st_q.rd_data;
    assign chan_led_out = st_q.led;
    assign chan_error_out = st_q.chan_err;

    // Checks on the record contents.
    property p_kind_read;
        @(posedge core_clk_in) disable iff (reset_in)
        rd_req_in.en && rd_req_in.addr == OFF_CHANNEL_KIND
        |=> rd_rsp_out.valid && rd_rsp_out.data == 8'h71;
    endproperty
    a_kind_read: assert property (p_kind_read)
        else $error("Channel kind byte is not 71h.");

    property p_bits_read;
        @(posedge core_clk_in) disable iff (reset_in)
        rd_req_in.en && rd_req_in.addr == OFF_DIAG_BITS
        |=> rd_rsp_out.data == 8'h08;
    endproperty
    a_bits_read: assert property (p_bits_read)
        else $error("Diagnostic bits per channel is not 08h.");

    property p_count_read;
        @(posedge core_clk_in) disable iff (reset_in)
        rd_req_in.en && rd_req_in.addr == OFF_CHANNEL_COUNT
        |=> rd_rsp_out.data == 8'h04;
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("Channel count byte is not 04h.");

    property p_summary_read;
        @(posedge core_clk_in) disable iff (reset_in)
        rd_req_in.en && rd_req_in.addr == OFF_GROUP_SUMMARY
        |=> rd_rsp_out.data[7:4] == 4'h0
            && rd_rsp_out.data[0] == $past(|chan_flags[0]);
    endproperty
    a_summary_read: assert property (p_summary_read)
        else $error("Group summary byte is wrong.");

    property p_cond_to_error;
        @(posedge core_clk_in) disable iff (reset_in)
        chan_cond_in[1].overflow |=> ##1 chan_error_out && chan_led_out[1];
    endproperty
    a_cond_to_error: assert property (p_cond_to_error)
        else $error("Overflow did not light indicator and error flag.");

    property p_general_bit;
        @(posedge core_clk_in) disable iff (reset_in)
        rd_req_in.en && rd_req_in.addr == OFF_GENERAL_DIAG
        |=> rd_rsp_out.data[3] == $past(|summary);
    endproperty
    a_general_bit: assert property (p_general_bit)
        else $error("General channel error bit is wrong.");

    property p_stamp;
        @(posedge core_clk_in) disable iff (reset_in)
        any_event |=> st_q.stamp == $past(st_q.ticker);
    endproperty
    a_stamp: assert property (p_stamp)
        else $error("Timestamp not captured on a diagnostic event.");

    property p_tick_step;
        @(posedge core_clk_in) disable iff (reset_in)
        tick |=> st_q.ticker == $past(st_q.ticker) + 32'h0000_0001;
    endproperty
    a_tick_step: assert property (p_tick_step)
        else $error("Ticker did not step on the prescaler wrap.");

    property p_tick_hold;
        @(posedge core_clk_in) disable iff (reset_in)
        !tick |=> $stable(st_q.ticker);
    endproperty
    a_tick_hold: assert property (p_tick_hold)
        else $error("Ticker moved between microsecond steps.");

    property p_tick_period;
        @(posedge core_clk_in) disable iff (reset_in)
        tick |=> !tick [*8] ##92 tick;
    endproperty
    a_tick_period: assert property (p_tick_period)
        else $error("Prescaler period is not 100 cycles.");

    property p_wrap;
        @(posedge core_clk_in) disable iff (reset_in)
        tick && st_q.ticker == TICKER_MAX |=> st_q.ticker == 32'h0000_0000;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("Ticker did not wrap to zero.");

    property p_start_zero;
        @(posedge core_clk_in)
        $fell(reset_in) |-> st_q.ticker == 32'h0000_0000;
    endproperty
    a_start_zero: assert property (p_start_zero)
        else $error("Ticker not zero after reset.");

    // Watch the registered error output so a lost channel 2 summary bit shows up.
    property p_flag_summary;
        @(posedge core_clk_in) disable iff (reset_in)
        |chan_flags[2] |=> chan_error_out;
    endproperty
    a_flag_summary: assert property (p_flag_summary)
        else $error("Summary bit missing for an erring channel.");
endmodule // aidr_diag_record
`default_nettype wire

// ==== aidr_pkg.sv ====
// Purpose: Shared constants and types of the analog input diagnostic record.
// Assumes: One 100 MHz module clock and a byte-wide record read port.
// Notes: The record byte offsets follow the diagnostic record byte order.
`default_nettype none
package aidr_pkg;

    // Clock and ticker timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_PERIOD_NS = 1000;
    localparam int PRESCALE_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [6:0] PRESCALE_LAST = 7'(PRESCALE_CYC - 1);
    localparam logic [31:0] TICKER_RESET = 32'h0000_0000;
    localparam logic [31:0] TICKER_MAX = 32'hFFFF_FFFF;

    // Byte offsets inside the diagnostic record.
    localparam logic [4:0] OFF_GENERAL_DIAG = 5'h00;
    localparam logic [4:0] OFF_MODULE_INFO = 5'h01;
    localparam logic [4:0] OFF_RESERVED_C = 5'h02;
    localparam logic [4:0] OFF_INTERNAL_DIAG = 5'h03;
    localparam logic [4:0] OFF_CHANNEL_KIND = 5'h04;
    localparam logic [4:0] OFF_DIAG_BITS = 5'h05;
    localparam logic [4:0] OFF_CHANNEL_COUNT = 5'h06;
    localparam logic [4:0] OFF_GROUP_SUMMARY = 5'h07;
    localparam logic [4:0] OFF_CHAN0_FLAGS = 5'h08;
    localparam logic [4:0] OFF_UNUSED_FLAGS = 5'h0C;
    localparam logic [4:0] OFF_TIMESTAMP = 5'h10;
    localparam logic [4:0] RECORD_LEN = 5'h14;

    // Fixed contents of the record.
    localparam logic [7:0] KIND_DIGITAL_IN = 8'h70;
    localparam logic [7:0] KIND_ANALOG_IN = 8'h71;
    localparam logic [7:0] KIND_DIGITAL_OUT = 8'h72;
    localparam logic [7:0] KIND_ANALOG_OUT = 8'h73;
    localparam logic [7:0] KIND_ANALOG_IO = 8'h74;
    localparam logic [7:0] KIND_COUNTER = 8'h76;
    localparam logic [7:0] DIAG_BITS_VAL = 8'h08;
    localparam logic [7:0] CHANNEL_COUNT_VAL = 8'h04;
    localparam logic [7:0] MODULE_INFO_VAL = 8'h15;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam int NUM_CHAN = 4;

    // Bit positions.
    localparam int BIT_PARAM_ERR = 0;
    localparam int BIT_UNDERFLOW = 6;
    localparam int BIT_OVERFLOW = 7;
    localparam int BIT_GEN_CHAN_ERR = 3;

    // Carrier types.
    typedef struct packed {
        logic param_err;
        logic underflow;
        logic overflow;
    } aidr_chan_in_t;

    typedef struct packed {
        logic en;
        logic [4:0] addr;
    } aidr_rd_req_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } aidr_rd_rsp_t;

endpackage
`default_nettype wire

// ==== aidr_chan_err.sv ====
// Purpose: Error byte, indicator and event pulse of one analog channel.
// Assumes: Condition inputs are levels synchronous to the clock.
// Notes: Flags follow the present condition; they are not sticky.
`timescale 1ns/100ps
`default_nettype none
module aidr_chan_err (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_in,
    // Channel conditions.
    input wire aidr_pkg::aidr_chan_in_t cond_in,
    // Error byte, indicator and event pulse.
    output logic [7:0] flags_out,
    output logic led_out,
    output logic event_out
);
    import aidr_pkg::*;

    typedef struct packed {
        logic [7:0] flags;
        logic led;
        logic event_p;
    } aidr_chan_st_t;

    aidr_chan_st_t st_q;
    aidr_chan_st_t st_d;

    // Build the error byte; reserved bits 5 to 1 always stay zero.
    always_comb begin
        st_d = st_q;
        st_d.flags = BYTE_ZERO;
        st_d.flags[BIT_PARAM_ERR] = cond_in.param_err;
        st_d.flags[BIT_UNDERFLOW] = cond_in.underflow;
        st_d.flags[BIT_OVERFLOW] = cond_in.overflow;
        st_d.led = |st_d.flags;
        // A new error bit appearing is a diagnostic event.
        st_d.event_p = |(st_d.flags & ~st_q.flags);
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags_out = st_q.flags;
    assign led_out = st_q.led;
    assign event_out = st_q.event_p;

    property p_param_bit;
        @(posedge core_clk_in) disable iff (reset_in)
        cond_in.param_err |=> flags_out[0];
    endproperty
    a_param_bit: assert property (p_param_bit)
        else $error("Parameter error bit not set.");

    property p_under_bit;
        @(posedge core_clk_in) disable iff (reset_in)
        1'b1 |=> flags_out[6] == $past(cond_in.underflow);
    endproperty
    a_under_bit: assert property (p_under_bit)
        else $error("Underflow bit does not follow its condition.");

    property p_over_bit;
        @(posedge core_clk_in) disable iff (reset_in)
        1'b1 |=> flags_out[7] == $past(cond_in.overflow);
    endproperty
    a_over_bit: assert property (p_over_bit)
        else $error("Overflow bit does not follow its condition.");
endmodule // aidr_chan_err
`default_nettype wire

// ==== aidr_coupler.sv ====
// Purpose: Behavioural backplane coupler that reads diagnostic record bytes.
// Assumes: One byte per call; the answer stands one cycle after the strobe.
// Notes: The idle address is inverted so a stale offset never passes.
`timescale 1ns/100ps
`default_nettype none
module aidr_coupler (
    // Clock.
    input wire logic core_clk_in,
    // Record read port.
    output var aidr_pkg::aidr_rd_req_t rd_req_out,
    input wire aidr_pkg::aidr_rd_rsp_t rd_rsp_in
);
    import aidr_pkg::*;

    // No strobe at time zero.
    initial begin
        rd_req_out = '{en: 1'b0, addr: 5'h1F};
    end

    // Strobe for one edge, then take the answer once that edge has landed.
    task automatic read_byte(input logic [4:0] addr, output logic valid,
                             output logic [7:0] data);
        @(posedge core_clk_in);
        rd_req_out <= '{en: 1'b1, addr: addr};
        @(posedge core_clk_in);
        rd_req_out <= '{en: 1'b0, addr: ~addr};
        #1;
        valid = rd_rsp_in.valid;
        data = rd_rsp_in.data;
    endtask
endmodule // aidr_coupler
`default_nettype wire

// ==== aidr_tb.sv ====
// Purpose: Self-checking bench of the analog input diagnostic record.
// Assumes: 100 MHz clock; ticker steps every 100 edges after reset release.
// Notes: Events are raised mid-microsecond so the stamp is unambiguous.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import aidr_pkg::*;

    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    aidr_chan_in_t cond [NUM_CHAN];
    aidr_rd_req_t rd_req;
    aidr_rd_rsp_t rd_rsp;
    logic [3:0] chan_led;
    logic chan_error;
    int n_errors = 0;
    int samples_checked = 0;
    int n_edges = 0;

    // Free-running clock.
    always #5 core_clk_in = ~core_clk_in;

    // Edges since reset release; the expected ticker is this over 100.
    always @(posedge core_clk_in) begin
        if (reset_in)
            n_edges <= 0;
        else
            n_edges <= n_edges + 1;
    end

    aidr_diag_record DUT (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .chan_cond_in(cond),
        .rd_req_in(rd_req),
        .rd_rsp_out(rd_rsp),
        .chan_led_out(chan_led),
        .chan_error_out(chan_error)
    );

    aidr_coupler coupler (
        .core_clk_in(core_clk_in),
        .rd_req_out(rd_req),
        .rd_rsp_in(rd_rsp)
    );

    // Ends the run; both the main sequence and the watchdog come here.
    task automatic close_out();
        $display("Checks: %0d, mismatches: %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // The one value compare; narrower results are zero extended.
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp,
                             input string what);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
                     got, exp);
        end
    endtask

    // One record read; valid must accompany the byte.
    task automatic rd_chk(input logic [4:0] addr, input logic [7:0] exp,
                          input string what);
        logic v;
        logic [7:0] d;
        coupler.read_byte(addr, v, d);
        check_val({23'h0, v, d}, {23'h0, 1'b1, exp}, what);
    endtask

    // Fixed bytes, cleared error bytes, reserved and unmapped offsets.
    task automatic t_fixed_bytes();
        #1;
        check_val(32'(rd_rsp), 32'h0, "idle answer");
        rd_chk(OFF_CHANNEL_KIND, 8'h71, "kind");
        rd_chk(OFF_DIAG_BITS, 8'h08, "diag bits");
        rd_chk(OFF_CHANNEL_COUNT, 8'h04, "channels");
        rd_chk(OFF_GROUP_SUMMARY, 8'h00, "summary");
        rd_chk(OFF_GENERAL_DIAG, 8'h00, "general");
        rd_chk(OFF_MODULE_INFO, MODULE_INFO_VAL, "module info");
        for (int a = 2; a < 4; a++)
            rd_chk(5'(a), 8'h00, "reserved head");
        for (int a = 8; a < 16; a++)
            rd_chk(5'(a), 8'h00, "chan or reserved");
        for (int a = 16; a < 20; a++)
            rd_chk(5'(a), 8'h00, "stamp at start");
        rd_chk(5'h1F, 8'h00, "unmapped");
    endtask

    // Every condition on every channel, set and then dropped again.
    task automatic t_chan_flags();
        aidr_chan_in_t c;
        logic [7:0] e;
        for (int ch = 0; ch < NUM_CHAN; ch++) begin
            for (int k = 0; k < 3; k++) begin
                c = aidr_chan_in_t'(3'b100 >> k);
                e = (k == 0) ? 8'h01 : ((k == 1) ? 8'h40 : 8'h80);
                @(posedge core_clk_in);
                cond[ch] <= c;
                repeat (3) @(posedge core_clk_in);
                #1;
                check_val({chan_error, chan_led}, {1'b1, 4'(1 << ch)},
                          "indicators");
                rd_chk(5'(8 + ch), e, "flags");
                rd_chk(OFF_GROUP_SUMMARY, 8'(1 << ch), "summary");
                rd_chk(OFF_GENERAL_DIAG, 8'h08, "general");
                @(posedge core_clk_in);
                cond[ch] <= '0;
                repeat (3) @(posedge core_clk_in);
                #1;
                check_val({chan_error, chan_led}, 32'h0, "dark");
                rd_chk(5'(8 + ch), 8'h00, "flags clear");
            end
        end
    endtask

    // Raise an underflow halfway through a microsecond, then read the stamp.
    task automatic t_stamp(input int ch, input int tick);
        logic [31:0] got;
        logic [7:0] d;
        logic v;
        got = '0;
        do
            @(posedge core_clk_in);
        while (n_edges != tick * 100 + 49);
        cond[ch] <= '{param_err: 1'b0, underflow: 1'b1, overflow: 1'b0};
        repeat (4) @(posedge core_clk_in);
        cond[ch] <= '0;
        // Bytes come most significant first.
        for (int i = 0; i < 4; i++) begin
            coupler.read_byte(5'(16 + i), v, d);
            got = {got[23:0], d};
        end
        check_val(got, 32'(tick), "stamp");
    endtask

    // Main sequence.
    initial begin
        for (int i = 0; i < NUM_CHAN; i++)
            cond[i] = '0;
        repeat (8) @(posedge core_clk_in);
        reset_in <= 1'b0;
        t_fixed_bytes();
        t_chan_flags();
        t_stamp(2, 4);
        t_stamp(1, 7);
        close_out();
    end

    // Watchdog: the tests need well under 1500 edges.
    initial begin
        repeat (5000) @(posedge core_clk_in);
        n_errors++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        close_out();
    end
endmodule // tb
`default_nettype wire
